/* File: bench/tty_char_source.sv */
// character source model feeding the receive fifo
`timescale 1ns/1ps
`default_nettype none
module tty_char_source
  import tty_input_pkg::*;
(
  input  wire logic              clk_sys_i,
  input  wire logic              rx_ready_i,
  output logic      [DATA_W-1:0] rx_data_o,
  output logic                   rx_valid_o
);
  logic [DATA_W-1:0] q [$];
  logic [DATA_W-1:0] last;
  task automatic push(input logic [DATA_W-1:0] c);
    q.push_back(c);
  endtask
  initial begin
    last = 8'h00;
    rx_valid_o = 1'b0;
    rx_data_o = 8'hff;
  end
  always @(posedge clk_sys_i) begin
    if (rx_valid_o && rx_ready_i) begin
      last = q.pop_front();
    end
    #10;
    rx_valid_o = q.size() > 0;
    rx_data_o = rx_valid_o ? q[0] : ~last;
  end
endmodule
`default_nettype wire

/* File: bench/tty_input_transfer_tb.sv */
// self-checking bench for the teletype input-transfer block
`timescale 1ns/1ps
`default_nettype none
module tty_input_transfer_tb;
  import tty_input_pkg::*;
  typedef struct packed {cmd_t c; logic [7:0] ch; logic [15:0] exp; logic x;} row_t;
  logic              clk_sys_i, nrst_i, rx_valid_i, rx_ready_o, cmd_valid_i, cmd_ready_o;
  logic [DATA_W-1:0] rx_data_i;
  cmd_t              cmd_i;
  line_op_t          line_op_i;
  logic [WORD_W-1:0] acc_i, idx_i, result_o;
  logic              result_valid_o, result_to_index_o, motor_on_o, rts_o, write_dir_o;
  logic              rts_b;
  int                n_errors, tests_run;
  row_t rows [6] = '{'{input_word_to_accumulator, 8'h41, 16'h0041, 1'b0},
                     '{input_word_to_index, 8'h42, 16'h0042, 1'b1},
                     '{input_byte_to_accumulator, 8'h43, 16'h5a43, 1'b0},
                     '{input_byte_to_index, 8'h44, 16'ha544, 1'b1},
                     '{wait_read_word_to_accumulator, 8'h45, 16'h0045, 1'b0},
                     '{wait_read_word_to_index, 8'h46, 16'h0046, 1'b1}};
  tty_input_transfer u_tty_input_transfer (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
    .rx_data_i(rx_data_i), .rx_valid_i(rx_valid_i), .rx_ready_o(rx_ready_o),
    .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i), .line_op_i(line_op_i), .cmd_ready_o(cmd_ready_o),
    .acc_i(acc_i), .idx_i(idx_i), .result_o(result_o), .result_valid_o(result_valid_o),
    .result_to_index_o(result_to_index_o), .motor_on_o(motor_on_o), .rts_o(rts_o),
    .write_dir_o(write_dir_o));
  tty_input_transfer #(.MODEM_FITTED(1'b0)) u_tty_input_transfer_b (.clk_sys_i(clk_sys_i),
    .nrst_i(nrst_i), .rx_data_i(rx_data_i), .rx_valid_i(rx_valid_i), .rx_ready_o(),
    .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i), .line_op_i(line_op_i), .cmd_ready_o(),
    .acc_i(acc_i), .idx_i(idx_i), .result_o(), .result_valid_o(), .result_to_index_o(),
    .motor_on_o(), .rts_o(rts_b), .write_dir_o());
  tty_char_source u_tty_char_source (.clk_sys_i(clk_sys_i), .rx_ready_i(rx_ready_o),
    .rx_data_o(rx_data_i), .rx_valid_o(rx_valid_i));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic do_cmd(input cmd_t c, input line_op_t op, input bit want);
    int k;
    @(posedge clk_sys_i);
    #10 cmd_valid_i = 1'b1;
    cmd_i = c;
    line_op_i = op;
    @(posedge clk_sys_i);
    #10 cmd_valid_i = 1'b0;
    chk(cmd_ready_o, 1'b0);
    k = 0;
    while (want && result_valid_o !== 1'b1 && k < 60) begin
      @(posedge clk_sys_i);
      #1 k++;
    end
    if (want) chk(result_valid_o, 1'b1);
    @(posedge clk_sys_i);
  endtask
  initial begin
    clk_sys_i = 1'b0;
    forever #50 clk_sys_i = ~clk_sys_i;
  end
  initial begin
    #(100 * 5000);
    n_errors++;
    wrap_up();
  end
  initial begin
    n_errors = 0;
    tests_run = 0;
    nrst_i = 1'b0;
    cmd_valid_i = 1'b0;
    cmd_i = cmd_none;
    line_op_i = line_motor_on;
    acc_i = 16'h5a11;
    idx_i = 16'ha522;
    repeat (3) @(posedge clk_sys_i);
    #10 nrst_i = 1'b1;
    chk({motor_on_o, rts_o, write_dir_o}, 3'b101);
    chk({cmd_ready_o, rx_ready_o}, 2'b11);
    $display("reset test done");
    do_cmd(cmd_line, line_rts_set, 1'b0);
    chk({rts_o, write_dir_o}, 2'b11);
    chk(rts_b, 1'b0);
    do_cmd(cmd_line, line_motor_off, 1'b0);
    chk(motor_on_o, 1'b0);
    do_cmd(cmd_line, line_rts_clear, 1'b0);
    chk({rts_o, motor_on_o, write_dir_o}, 3'b001);
    do_cmd(cmd_line, line_motor_on, 1'b0);
    chk(motor_on_o, 1'b1);
    $display("line control test done");
    foreach (rows[i]) begin
      u_tty_char_source.push(rows[i].ch);
      repeat (3) @(posedge clk_sys_i);
      do_cmd(rows[i].c, line_motor_on, 1'b1);
      chk(result_o, rows[i].exp);
      chk(result_to_index_o, rows[i].x);
    end
    $display("table test done");
    fork
      do_cmd(wait_read_word_to_index, line_motor_on, 1'b1);
      begin
        repeat (6) @(posedge clk_sys_i);
        #1 chk(result_valid_o, 1'b0);
        u_tty_char_source.push(8'h7e);
      end
    join
    chk(result_o, 16'h007e);
    chk(write_dir_o, 1'b0);
    $display("wait read test done");
    for (int i = 0; i < 9; i++) u_tty_char_source.push(8'h60 + i[7:0]);
    repeat (14) @(posedge clk_sys_i);
    chk(rx_ready_o, 1'b0);
    for (int i = 0; i < 9; i++) begin
      do_cmd(input_word_to_accumulator, line_motor_on, 1'b1);
      chk(result_o, 16'h0060 + i[15:0]);
    end
    chk(rx_ready_o, 1'b1);
    $display("fifo test done");
    do_cmd(cmd_line, line_rts_set, 1'b0);
    chk({rts_o, write_dir_o}, 2'b11);
    do_cmd(cmd_line, line_motor_off, 1'b0);
    #10 nrst_i = 1'b0;
    #1 chk({motor_on_o, rts_o}, 2'b10);
    repeat (2) @(posedge clk_sys_i);
    #10 nrst_i = 1'b1;
    @(posedge clk_sys_i);
    #1 chk(motor_on_o, 1'b1);
    $display("second reset test done");
    wrap_up();
  end
endmodule
`default_nettype wire

/* File: rtl/tty_fifo.sv */
// parameterised valid/ready fifo for received characters
`timescale 1ns/1ps
`default_nettype none
module tty_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             clk_sys_i,
  input  wire logic             nrst_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  output logic      [WIDTH-1:0] out_data_o,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic [AW-1:0]    next_wr_ptr;
  logic [AW-1:0]    next_rd_ptr;
  logic [AW:0]      next_count;
  logic             push;
  logic             pop;

  assign in_ready_o  = (count != (AW+1)'(DEPTH));
  assign out_valid_o = (count != '0);
  assign out_data_o  = mem[rd_ptr];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always_comb begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count  = count;
    if (push) begin
      next_wr_ptr = (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
    end
    if (pop) begin
      next_rd_ptr = (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  // count rises by one on a push without a pop
  fifo_count_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (push && !pop) |=> count == $past(count) + 1'b1)
    else $error("fifo count did not rise on push");
endmodule
`default_nettype wire

/* File: rtl/tty_input_pkg.sv */
// constants and types for the teletype input-transfer block
// Operation
// RL1: power-up or system reset always turns the terminal motor on, whatever was commanded before.
// RL2: the unconditional word input puts the buffer in the low byte of the chosen register and zeroes the high byte.
// RL3: the unconditional byte input writes the buffer into the low byte and keeps the register's high byte.
// RL4: the waiting word read first tests buffer full and only then delivers the buffer with the high byte zero.
// RL5: the clear request-to-send command works only when the modem interface option is fitted.
// RL6: a waiting read that finds the buffer empty keeps repeating until it fills, then completes.
// RL7: request-to-send raises the modem RTS line and puts the controller into write direction; the code does both only when MODEM_FITTED is set.
// RL8: clear request-to-send drops RTS and leaves all other controller state alone.
package tty_input_pkg;
  localparam int unsigned DATA_W    = 8;
  localparam int unsigned WORD_W    = 16;
  localparam int unsigned FIFO_DEPTH = 8;
  localparam logic [WORD_W-DATA_W-1:0] HIGH_ZERO = 8'h00;
  localparam logic MOTOR_ON_RST = 1'b1;
  localparam logic RTS_RST      = 1'b0;
  localparam logic WRITE_DIR_RST = 1'b1;

  // command codes presented on cmd_i
  typedef enum logic [2:0] {
    cmd_none                  = 3'h0,
    input_word_to_accumulator = 3'h1,
    input_word_to_index       = 3'h2,
    input_byte_to_accumulator = 3'h3,
    input_byte_to_index       = 3'h4,
    wait_read_word_to_accumulator = 3'h5,
    wait_read_word_to_index   = 3'h6,
    cmd_line                  = 3'h7
  } cmd_t;

  // line-control sub codes presented on line_op_i with cmd_line
  typedef enum logic [1:0] {
    line_motor_on  = 2'h0,
    line_motor_off = 2'h1,
    line_rts_set   = 2'h2,
    line_rts_clear = 2'h3
  } line_op_t;

  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_wait = 2'b01,
    st_done = 2'b11
  } state_t;
endpackage

/* File: rtl/tty_input_transfer.sv */
// teletype input transfer and line control toward the processor
`timescale 1ns/1ps
`default_nettype none
module tty_input_transfer
  import tty_input_pkg::*;
#(
  parameter int unsigned DEPTH       = FIFO_DEPTH,
  parameter bit          MODEM_FITTED = 1'b1
) (
  input  wire logic              clk_sys_i,
  input  wire logic              nrst_i,
  input  wire logic [DATA_W-1:0] rx_data_i,
  input  wire logic              rx_valid_i,
  output logic                   rx_ready_o,
  input  wire logic              cmd_valid_i,
  input  wire cmd_t              cmd_i,
  input  wire line_op_t          line_op_i,
  output logic                   cmd_ready_o,
  input  wire logic [WORD_W-1:0] acc_i,
  input  wire logic [WORD_W-1:0] idx_i,
  output logic      [WORD_W-1:0] result_o,
  output logic                   result_valid_o,
  output logic                   result_to_index_o,
  output logic                   motor_on_o,
  output logic                   rts_o,
  output logic                   write_dir_o
);
  logic [DATA_W-1:0] buf_data;
  logic              buf_full;
  logic              buf_pop;
  state_t            state;
  state_t            next_state;
  cmd_t              held_cmd;
  cmd_t              next_held_cmd;
  logic [WORD_W-1:0] next_result;
  logic              next_result_valid;
  logic              next_result_to_index;
  logic              next_motor_on;
  logic              next_rts;
  logic              next_write_dir;
  logic              take;
  logic              is_read;

  tty_fifo #(.WIDTH(DATA_W), .DEPTH(DEPTH)) u_fifo (
    .clk_sys_i   (clk_sys_i),
    .nrst_i      (nrst_i),
    .in_data_i   (rx_data_i),
    .in_valid_i  (rx_valid_i),
    .in_ready_o  (rx_ready_o),
    .out_data_o  (buf_data),
    .out_valid_o (buf_full),
    .out_ready_i (buf_pop)
  );

  assign cmd_ready_o = (state == st_idle);
  assign take        = cmd_valid_i && cmd_ready_o;
  assign is_read     = (cmd_i == wait_read_word_to_accumulator)
                    || (cmd_i == wait_read_word_to_index);

  always_comb begin
    next_state           = state;
    next_held_cmd        = held_cmd;
    next_result          = result_o;
    next_result_valid    = 1'b0;
    next_result_to_index = result_to_index_o;
    next_motor_on        = motor_on_o;
    next_rts             = rts_o;
    next_write_dir       = write_dir_o;
    buf_pop              = 1'b0;
    unique case (state)
      st_idle: begin
        if (take) begin
          unique case (cmd_i)
            // RL2 word zero high
            input_word_to_accumulator, input_word_to_index: begin
              next_result          = {HIGH_ZERO, buf_data};
              next_result_valid    = 1'b1;
              next_result_to_index = (cmd_i == input_word_to_index);
              buf_pop              = buf_full;
              next_state           = st_done;
            end
            // RL3 byte keep high
            input_byte_to_accumulator, input_byte_to_index: begin
              next_result_to_index = (cmd_i == input_byte_to_index);
              next_result = (cmd_i == input_byte_to_index)
                          ? {idx_i[WORD_W-1:DATA_W], buf_data}
                          : {acc_i[WORD_W-1:DATA_W], buf_data};
              next_result_valid    = 1'b1;
              buf_pop              = buf_full;
              next_state           = st_done;
            end
            // RL6 start waiting read
            wait_read_word_to_accumulator, wait_read_word_to_index: begin
              next_held_cmd  = cmd_i;
              next_state     = st_wait;
              // read direction while waiting
              next_write_dir = 1'b0;
            end
            cmd_line: begin
              next_state = st_done;
              unique case (line_op_i)
                line_motor_on: begin
                  next_motor_on  = 1'b1;
                  next_write_dir = 1'b1;
                end
                line_motor_off: begin
                  next_motor_on  = 1'b0;
                  next_write_dir = 1'b1;
                end
                // RL7 rts set write
                line_rts_set: begin
                  if (MODEM_FITTED) begin
                    next_rts       = 1'b1;
                    next_write_dir = 1'b1;
                  end
                end
                // RL5 RL8 rts clear optional
                line_rts_clear: begin
                  if (MODEM_FITTED) begin
                    next_rts = 1'b0;
                  end
                end
              endcase
            end
            default: next_state = st_idle;
          endcase
        end
      end
      // RL4 RL6 wait for full
      st_wait: begin
        if (buf_full) begin
          next_result          = {HIGH_ZERO, buf_data};
          next_result_valid    = 1'b1;
          next_result_to_index = (held_cmd == wait_read_word_to_index);
          buf_pop              = 1'b1;
          next_state           = st_done;
        end
      end
      st_done: next_state = st_idle;
      default: next_state = st_idle;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state             <= st_idle;
      held_cmd          <= cmd_none;
      result_o          <= '0;
      result_valid_o    <= 1'b0;
      result_to_index_o <= 1'b0;
      // RL1 motor on reset
      motor_on_o        <= MOTOR_ON_RST;
      rts_o             <= RTS_RST;
      write_dir_o       <= WRITE_DIR_RST;
    end else begin
      state             <= next_state;
      held_cmd          <= next_held_cmd;
      result_o          <= next_result;
      result_valid_o    <= next_result_valid;
      result_to_index_o <= next_result_to_index;
      motor_on_o        <= next_motor_on;
      rts_o             <= next_rts;
      write_dir_o       <= next_write_dir;
    end
  end

  sequence read_issued_s;
    take && is_read;
  endsequence

  sequence buffer_empty_s;
    !buf_full;
  endsequence

  motor_reset_on_a: assert property (@(posedge clk_sys_i)
    $rose(nrst_i) |-> motor_on_o) // RL1
    else $error("motor not on after reset");

  word_high_zero_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (take && (cmd_i == input_word_to_accumulator || cmd_i == input_word_to_index))
    |=> result_valid_o && result_o == {HIGH_ZERO, $past(buf_data)}) // RL2
    else $error("word input wrong");

  byte_keeps_high_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (take && cmd_i == input_byte_to_accumulator)
    |=> result_o == {$past(acc_i[WORD_W-1:DATA_W]), $past(buf_data)}) // RL3
    else $error("byte input changed high byte");

  read_needs_full_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (state == st_wait && buf_full)
    |=> result_valid_o && result_o[WORD_W-1:DATA_W] == HIGH_ZERO) // RL4
    else $error("wait read did not deliver");

  read_holds_empty_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    read_issued_s ##1 buffer_empty_s |=> !result_valid_o && state == st_wait) // RL6
    else $error("wait read completed on empty buffer");

  rts_set_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (MODEM_FITTED && take && cmd_i == cmd_line && line_op_i == line_rts_set)
    |=> rts_o && write_dir_o) // RL7
    else $error("rts set failed");

  rts_clear_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (take && cmd_i == cmd_line && line_op_i == line_rts_clear)
    |=> rts_o == (MODEM_FITTED ? 1'b0 : $past(rts_o))
        && $stable(motor_on_o) && $stable(write_dir_o)) // RL5 RL8
    else $error("rts clear wrong");

  busy_while_wait_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // RL6
    state == st_wait |-> !cmd_ready_o)
    else $error("ready during wait");
endmodule
`default_nettype wire
